// File: txo_pkg.sv
/*
 * Package for the tape extended-operations control block: instruction codes,
 * extended operations buffer bit positions, vectors, resets and carrier types.
 * Assumes the processor bit 0 is the word's most significant bit, so printed
 * bit n sits at vector index 11-n.
 */
package txo_pkg;

    localparam int          WORD_W           = 12;
    localparam int          BLOCK_W          = 11;
    localparam int          BANK_W           = 3;
    localparam int          UNIT_W           = 3;

    // Instruction codes
    localparam logic [11:0] OP_ACC_TO_EXT    = 12'h001;
    localparam logic [11:0] OP_TAPE_ACC      = 12'h003;
    localparam logic [11:0] OP_EXT_TO_ACC    = 12'h011;
    localparam logic [11:0] OP_LOAD_SETUP    = 12'h013;
    localparam logic [11:0] OP_SKIP_DONE     = 12'h10e;
    localparam logic [11:0] OP_MAINT_LOAD    = 12'hc69;
    localparam logic [5:0]  OP_TAPE_GROUP    = 6'h07;
    localparam int          INSTR_I_POS      = 4;
    localparam int          INSTR_UNIT_POS   = 3;
    localparam logic [2:0]  TOP_GROUP_READ   = 3'h1;
    localparam logic [2:0]  TOP_GROUP_WRITE  = 3'h5;

    // Extended operations buffer bit positions
    localparam int          EOB_BANK_LSB     = 9;
    localparam int          EOB_FORMAT       = 7;
    localparam int          EOB_INT_EN       = 6;
    localparam int          EOB_MAINT        = 5;
    localparam int          EOB_EXT_ADDR     = 4;
    localparam int          EOB_NO_WAIT      = 3;
    localparam int          EOB_HOLD         = 2;
    localparam int          EOB_UNIT_HI      = 1;
    localparam int          EOB_UNIT_MID     = 0;

    // Accumulator select bits of the maintenance load and of the buffer load
    localparam int          ACC_CLEAR_SEL    = 7;
    localparam int          ACC_SKIP_SEL     = 6;
    localparam int          ACC_FORMAT       = 7;

    // Fixed locations in field 0
    localparam logic [11:0] VEC_PRI_SAVE     = 12'h020;
    localparam logic [11:0] VEC_PRI_JUMP     = 12'h021;
    localparam logic [11:0] VEC_ALT_SAVE     = 12'h000;
    localparam logic [11:0] VEC_ALT_JUMP     = 12'h001;
    localparam logic [11:0] VEC_TRAP         = 12'h060;

    localparam logic [11:0] RST_EOB          = 12'h000;
    localparam logic [11:0] RST_WORD         = 12'h000;

    typedef struct packed {
        logic [2:0]         op;
        logic               motion_i;
        logic [UNIT_W-1:0]  unit;
        logic [BLOCK_W-1:0] block;
    } txo_cmd_t;

    typedef struct packed {
        logic [BANK_W-1:0]  bank;
        logic [WORD_W-1:0]  addr;
    } txo_mem_addr_t;

    typedef enum logic [0:0] {
        TXO_IDLE,
        TXO_RUN
    } txo_state_t;

endpackage

// File: txo_ctrl.sv
/*
 * Tape extended-operations control: decodes tape instructions from the
 * processor, holds the extended operations buffer and setup address, runs
 * the per-operation address counter, done flag, skip, stall and interrupt.
 * Assumes one instruction strobe per cycle at most, and that the transport
 * side reports one word strobe per memory word and one finish per operation.
 */
// Summary of operation
// - Buffer bit 7 enables extended address mode
// - Extended mode: setup address copied to counter
// - Extended mode: second word is 11-bit block
// - Extended mode: bank from buffer bits 0-2
// - Address wraps inside bank, 7777 to 0000
// - Code 0023 loads accumulator into setup register
// - Unit is buffer bits 10,11 plus bit 8
// - Buffer bit 5 enables done interrupt request
// - Interrupt uses 0040/0041, alternate 0000/0001
// - Done set at finish, cleared by instruction/maintenance
// - Buffer bit 8 releases processor after start
// - Maintenance load skips on done, clears done
// - Skip-on-done: I=0 idle skips, I=1 busy skips
// - No-wait mode leaves check out of accumulator
// - Deselected transport stops unless buffer bit 9
// - Format bit set only with switch held
// - Buffer bit 6 substitutes maintenance signals
// - Both traps enabled: trap to 0140
// - Code 0001 loads accumulator into buffer
// - Code 0021 copies buffer into accumulator
`timescale 1ns/1ps

module txo_ctrl #(
    parameter int UNITS = 8
) (
    input  wire logic                  ref_clk_in,      // 10 MHz clock
    input  wire logic                  rst_in,          // Sync reset, active high
    input  wire logic                  instr_valid_in,  // Instruction strobe
    input  wire logic [11:0]           instr_in,        // First instruction word
    input  wire logic [11:0]           word2_in,        // Second instruction word
    input  wire logic [11:0]           acc_in,          // Processor accumulator
    input  wire logic [2:0]            data_field_in,   // Processor data field
    input  wire logic                  mode_alt_in,     // Alternate processor mode
    input  wire logic                  int_sys_en_in,   // Interrupt system enabled
    input  wire logic                  tape_trap_en_in, // Tape trap function on
    input  wire logic                  instr_trap_en_in,// Instruction trap function on
    input  wire logic                  format_sw_in,    // Console format switch held
    input  wire logic                  rw_word_in,      // Reader-writer word strobe
    input  wire logic                  rw_finish_in,    // Reader-writer op finished
    input  wire logic [11:0]           rw_check_in,     // Reader-writer transfer check
    input  wire logic                  mt_word_in,      // Maintenance word strobe
    input  wire logic                  mt_finish_in,    // Maintenance op finished
    input  wire logic [11:0]           mt_check_in,     // Maintenance transfer check
    input  wire logic [UNITS-1:0]      unit_stop_in,    // Transport stopped by motion
    output logic [11:0]                acc_out,         // Value for accumulator
    output logic                       acc_load_out,    // Accumulator load pulse
    output logic                       skip_out,        // Skip next pulse
    output logic                       stall_out,       // Processor must wait
    output logic                       int_req_out,     // Interrupt request level
    output logic [11:0]                int_save_out,    // Location for saved PC
    output logic [11:0]                int_jump_out,    // Interrupt continue address
    output logic                       trap_out,        // Trap pulse
    output logic [11:0]                trap_addr_out,   // Trap location, field 0
    output logic                       tape_start_out,  // Operation start pulse
    output txo_pkg::txo_cmd_t          tape_cmd_out,    // Operation command
    output txo_pkg::txo_mem_addr_t     mem_addr_out,    // Transfer memory address
    output logic [UNITS-1:0]           unit_run_out,    // Per-transport motion enable
    output logic                       format_en_out,   // Format track enable
    output logic                       maint_mode_out,  // Maintenance mode active
    output logic                       busy_out         // Operation in progress
);
    import txo_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic [11:0]       eob_reg;
    logic [11:0]       setup_reg;
    logic [11:0]       addr_cnt_reg;
    logic [2:0]        bank_reg;
    logic [11:0]       chk_hold_reg;
    logic              done_reg;
    logic              nowait_op_reg;
    txo_state_t        state_reg;
    txo_cmd_t          cmd_reg;
    logic [UNITS-1:0]  run_reg;

    logic              is_tape;
    logic              trapped;
    logic              go_tape;
    logic              is_maint;
    logic              word_stb;
    logic              finish_stb;
    logic [11:0]       check_val;
    logic [UNIT_W-1:0] unit_sel;
    logic              ext_mode;

    assign ext_mode   = eob_reg[EOB_EXT_ADDR];
    assign is_tape    = instr_valid_in && (instr_in[11:6] == OP_TAPE_GROUP);
    assign trapped    = is_tape && tape_trap_en_in && instr_trap_en_in;
    assign go_tape    = is_tape && !trapped;
    assign is_maint   = instr_valid_in && (instr_in == OP_MAINT_LOAD);
    assign unit_sel   = {eob_reg[EOB_UNIT_HI], eob_reg[EOB_UNIT_MID],
                         instr_in[INSTR_UNIT_POS]};

    // Maintenance mode blocks the reader-writers
    assign word_stb   = eob_reg[EOB_MAINT] ? mt_word_in   : rw_word_in;
    assign finish_stb = eob_reg[EOB_MAINT] ? mt_finish_in : rw_finish_in;
    assign check_val  = eob_reg[EOB_MAINT] ? mt_check_in  : rw_check_in;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer and setup registers

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            eob_reg <= RST_EOB;
        end else if (instr_valid_in && instr_in == OP_ACC_TO_EXT) begin
            eob_reg              <= acc_in;
            eob_reg[EOB_FORMAT]  <= acc_in[ACC_FORMAT] && format_sw_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            setup_reg <= RST_WORD;
        end else if (instr_valid_in && instr_in == OP_LOAD_SETUP) begin
            setup_reg <= acc_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencing

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg     <= TXO_IDLE;
            nowait_op_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                TXO_IDLE: begin
                    if (go_tape) begin
                        state_reg     <= TXO_RUN;
                        nowait_op_reg <= eob_reg[EOB_NO_WAIT];
                    end
                end
                TXO_RUN: begin
                    if (finish_stb) begin
                        state_reg <= TXO_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cmd_reg  <= '0;
            bank_reg <= 3'h0;
        end else if (go_tape && state_reg == TXO_IDLE) begin
            cmd_reg.op       <= instr_in[2:0];
            cmd_reg.motion_i <= instr_in[INSTR_I_POS];
            cmd_reg.unit     <= unit_sel;
            cmd_reg.block    <= word2_in[BLOCK_W-1:0];
            bank_reg         <= ext_mode ? eob_reg[11:EOB_BANK_LSB]
                                         : data_field_in;
        end
    end

    // Counter is 12 bits, so the increment wraps inside the bank
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            addr_cnt_reg <= RST_WORD;
        end else if (go_tape && state_reg == TXO_IDLE) begin
            addr_cnt_reg <= ext_mode ? setup_reg : RST_WORD;
        end else if (state_reg == TXO_RUN && word_stb) begin
            addr_cnt_reg <= addr_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tape_start_out <= 1'b0;
        end else begin
            tape_start_out <= go_tape && state_reg == TXO_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag: a finish wins over any clear in the same cycle

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            done_reg <= 1'b0;
        end else if (state_reg == TXO_RUN && finish_stb) begin
            done_reg <= 1'b1;
        end else if (go_tape) begin
            done_reg <= 1'b0;
        end else if (is_maint && acc_in[ACC_CLEAR_SEL]) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            chk_hold_reg <= RST_WORD;
        end else if (state_reg == TXO_RUN && finish_stb) begin
            chk_hold_reg <= check_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator and skip answers

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            acc_out      <= RST_WORD;
            acc_load_out <= 1'b0;
        end else begin
            acc_load_out <= 1'b0;
            if (state_reg == TXO_RUN && finish_stb && !nowait_op_reg) begin
                acc_out      <= check_val;
                acc_load_out <= 1'b1;
            end else if (instr_valid_in && instr_in == OP_EXT_TO_ACC) begin
                acc_out      <= eob_reg;
                acc_load_out <= 1'b1;
            end else if (instr_valid_in && instr_in == OP_TAPE_ACC) begin
                acc_out      <= chk_hold_reg;
                acc_load_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            skip_out <= 1'b0;
        end else if (instr_valid_in && (instr_in & ~12'h010) == OP_SKIP_DONE) begin
            skip_out <= instr_in[INSTR_I_POS] ? busy_out : !busy_out;
        end else begin
            skip_out <= is_maint && acc_in[ACC_SKIP_SEL] && done_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt and trap

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            int_req_out  <= 1'b0;
            int_save_out <= VEC_PRI_SAVE;
            int_jump_out <= VEC_PRI_JUMP;
        end else begin
            int_req_out  <= eob_reg[EOB_INT_EN] && int_sys_en_in && done_reg;
            int_save_out <= mode_alt_in ? VEC_ALT_SAVE : VEC_PRI_SAVE;
            int_jump_out <= mode_alt_in ? VEC_ALT_JUMP : VEC_PRI_JUMP;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            trap_out      <= 1'b0;
            trap_addr_out <= VEC_TRAP;
        end else begin
            trap_out      <= trapped;
            trap_addr_out <= VEC_TRAP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transport motion

    genvar u;
    generate
        for (u = 0; u < UNITS; u++) begin : g_unit
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    run_reg[u] <= 1'b0;
                end else if (go_tape && state_reg == TXO_IDLE) begin
                    if (unit_sel == UNIT_W'(u)) begin
                        run_reg[u] <= 1'b1;
                    end else if (!eob_reg[EOB_HOLD]) begin
                        run_reg[u] <= 1'b0;
                    end
                end else if (unit_stop_in[u]) begin
                    run_reg[u] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign busy_out       = (state_reg == TXO_RUN);
    assign stall_out      = busy_out && !nowait_op_reg;
    assign tape_cmd_out   = cmd_reg;
    assign mem_addr_out   = '{bank: bank_reg, addr: addr_cnt_reg};
    assign unit_run_out   = run_reg;
    assign format_en_out  = eob_reg[EOB_FORMAT];
    assign maint_mode_out = eob_reg[EOB_MAINT];

endmodule

// File: txo_checker.sv
/* Port assertions and covers for txo_ctrl.
   Assumes binding to every txo_ctrl instance; bind at the foot. */
`timescale 1ns/1ps
module txo_checker #(
    parameter int UNITS = 8
) (
    input wire logic                   ref_clk_in,       // Clock
    input wire logic                   rst_in,           // Sync reset
    input wire logic                   instr_valid_in,   // Instruction strobe
    input wire logic [11:0]            instr_in,         // First word
    input wire logic [11:0]            word2_in,         // Second word
    input wire logic [11:0]            acc_in,           // Accumulator
    input wire logic                   int_sys_en_in,    // Interrupts on
    input wire logic                   tape_trap_en_in,  // Tape trap on
    input wire logic                   instr_trap_en_in, // Instruction trap on
    input wire logic                   format_sw_in,     // Format switch held
    input wire logic                   rw_word_in,       // Word strobe
    input wire logic                   rw_finish_in,     // Finish strobe
    input wire logic [11:0]            rw_check_in,      // Transfer check
    input wire logic [11:0]            acc_out,          // Accumulator value
    input wire logic                   acc_load_out,     // Accumulator load
    input wire logic                   skip_out,         // Skip pulse
    input wire logic                   stall_out,        // Processor wait
    input wire logic                   int_req_out,      // Interrupt request
    input wire logic                   trap_out,         // Trap pulse
    input wire logic [11:0]            trap_addr_out,    // Trap location
    input wire logic                   tape_start_out,   // Start pulse
    input wire txo_pkg::txo_cmd_t      tape_cmd_out,     // Command
    input wire txo_pkg::txo_mem_addr_t mem_addr_out,     // Memory address
    input wire logic                   busy_out          // Operation running
);
    import txo_pkg::*;
    logic [11:0] eob_q;
    logic [11:0] setup_q;
    wire logic   tape_op = instr_valid_in && instr_in[11:6] == OP_TAPE_GROUP;
    wire logic   go = tape_op && !busy_out && !(tape_trap_en_in && instr_trap_en_in);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Shadow of buffer and setup register
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            eob_q <= RST_EOB;
        end else if (instr_valid_in && instr_in == OP_ACC_TO_EXT) begin
            eob_q             <= acc_in;
            eob_q[EOB_FORMAT] <= acc_in[ACC_FORMAT] && format_sw_in;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            setup_q <= RST_WORD;
        end else if (instr_valid_in && instr_in == OP_LOAD_SETUP) begin
            setup_q <= acc_in;
        end
    end
    // No-wait choice is latched at each start
    logic nowait_q;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            nowait_q <= 1'b0;
        end else if (go) begin
            nowait_q <= eob_q[EOB_NO_WAIT];
        end
    end
    a_skip_idle: assert property (
        instr_valid_in && instr_in == OP_SKIP_DONE |=> skip_out == !$past(busy_out))
        else $error("skip on idle wrong");
    a_skip_busy: assert property (
        instr_valid_in && instr_in == (OP_SKIP_DONE | 12'h010) |=> skip_out == $past(busy_out))
        else $error("skip on busy wrong");
    a_buf_readback: assert property (
        instr_valid_in && instr_in == OP_EXT_TO_ACC |=> acc_load_out && acc_out == $past(eob_q))
        else $error("buffer readback wrong");
    a_ext_start: assert property (
        go && eob_q[EOB_EXT_ADDR] |=> tape_start_out
        && mem_addr_out == {$past(eob_q[11:9]), $past(setup_q)}
        && tape_cmd_out.block == $past(word2_in[10:0])
        && tape_cmd_out.unit == {$past(eob_q[1:0]), $past(instr_in[INSTR_UNIT_POS])})
        else $error("extended start wrong");
    a_trap_tape: assert property (
        tape_op && tape_trap_en_in && instr_trap_en_in |=> trap_out && !tape_start_out
        && trap_addr_out == VEC_TRAP) else $error("trap wrong");
    a_addr_wrap: assert property (
        busy_out && rw_word_in && !eob_q[EOB_MAINT] |=> $stable(mem_addr_out.bank)
        && mem_addr_out.addr == $past(mem_addr_out.addr) + 12'h001)
        else $error("address step wrong");
    a_done_acc: assert property (
        busy_out && rw_finish_in && !eob_q[EOB_MAINT] && !nowait_q
        |=> !busy_out && acc_load_out && acc_out == $past(rw_check_in))
        else $error("finish load wrong");
    a_nowait_acc: assert property (
        busy_out && rw_finish_in && !eob_q[EOB_MAINT] && nowait_q
        |=> !busy_out && !acc_load_out) else $error("no-wait loaded accumulator");
    a_stall_busy: assert property (
        stall_out == (busy_out && !nowait_q)) else $error("stall wrong");
    a_int_cause: assert property (
        $rose(int_req_out) |-> $past(int_sys_en_in && eob_q[EOB_INT_EN]))
        else $error("interrupt without cause");
    c_start: cover property (tape_start_out);
    c_trap: cover property (trap_out);
    c_skip_busy: cover property (skip_out && busy_out);
endmodule

bind txo_ctrl txo_checker #(.UNITS(UNITS)) u_chk (.ref_clk_in, .rst_in, .instr_valid_in,
    .instr_in, .word2_in, .acc_in, .int_sys_en_in, .tape_trap_en_in, .instr_trap_en_in,
    .rw_word_in, .rw_finish_in, .rw_check_in, .acc_out, .acc_load_out, .skip_out, .stall_out,
    .int_req_out, .trap_out, .trap_addr_out, .tape_start_out, .tape_cmd_out, .mem_addr_out,
    .busy_out, .format_sw_in);

// File: txo_tape_model.sv
/* Reader-writer model: word strobes, then a finish with its check.
   Assumes the control's start pulse as its start. */
`timescale 1ns/1ps
module txo_tape_model #(
    parameter int WORDS = 4
) (
    input  wire logic        clk_in,       // Clock
    input  wire logic        rst_in,       // Sync reset
    input  wire logic        start_in,     // Operation start
    input  wire logic        slow_in,      // Word every other cycle
    input  wire logic [11:0] check_val_in, // Check to report
    output logic             word_out,     // Word strobe
    output logic             finish_out,   // Operation finished
    output logic [11:0]      check_out     // Check, valid with finish
);
    int        left_reg;
    logic      tick_reg;
    wire logic go = left_reg > 0 && (tick_reg || !slow_in);
    always_ff @(posedge clk_in) begin
        tick_reg   <= rst_in ? 1'b0 : !tick_reg;
        word_out   <= go && left_reg > 1;
        finish_out <= go && left_reg == 1;
        // Check line toggles when not valid
        check_out  <= rst_in ? 12'h000 : (go && left_reg == 1) ? check_val_in : ~check_out;
        if (rst_in || start_in) begin
            left_reg <= rst_in ? 0 : WORDS + 1;
        end else if (go) begin
            left_reg <= left_reg - 1;
        end
    end
endmodule

// File: testbench.sv
/* Instruction-level tests of txo_ctrl against a transport model.
   Assumes txo_pkg codes and a 10 MHz clock. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    import txo_pkg::*;
    localparam int WORDS = 4;
    logic ref_clk_in, rst_in, instr_valid_in, mode_alt_in, int_sys_en_in, format_sw_in, mt_word_in;
    logic tape_trap_en_in, instr_trap_en_in, mt_finish_in, slow_in, rw_word_in, rw_finish_in;
    logic [11:0] instr_in, word2_in, acc_in, mt_check_in, check_val_in, rw_check_in;
    logic [2:0]  data_field_in;
    logic [11:0] acc_out, int_save_out, int_jump_out, trap_addr_out;
    logic acc_load_out, skip_out, stall_out, int_req_out, trap_out, tape_start_out;
    logic format_en_out, maint_mode_out, busy_out;
    logic [7:0]  unit_run_out;
    txo_cmd_t      tape_cmd_out;
    txo_mem_addr_t mem_addr_out;
    int err_total = 0;
    int checks = 0;
    txo_ctrl #(.UNITS(8)) uut (.ref_clk_in, .rst_in, .instr_valid_in, .instr_in, .word2_in,
        .acc_in, .data_field_in, .mode_alt_in, .int_sys_en_in, .tape_trap_en_in,
        .instr_trap_en_in, .format_sw_in, .rw_word_in, .rw_finish_in, .rw_check_in,
        .mt_word_in, .mt_finish_in, .mt_check_in, .unit_stop_in(8'h00), .acc_out,
        .acc_load_out, .skip_out, .stall_out, .int_req_out, .int_save_out, .int_jump_out,
        .trap_out, .trap_addr_out, .tape_start_out, .tape_cmd_out, .mem_addr_out,
        .unit_run_out, .format_en_out, .maint_mode_out, .busy_out);
    txo_tape_model #(.WORDS(WORDS)) model (.clk_in(ref_clk_in), .rst_in,
        .start_in(tape_start_out), .slow_in, .check_val_in, .word_out(rw_word_in),
        .finish_out(rw_finish_in), .check_out(rw_check_in));
    ////////////////////////////////////////
    task automatic op(input logic [11:0] i, input logic [11:0] a, input logic [11:0] w);
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b1;
        instr_in       <= i;
        acc_in         <= a;
        word2_in       <= w;
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    task automatic wait_idle;
        for (int n = 0; n < 100 && busy_out !== 1'b0; n++) begin
            @(posedge ref_clk_in);
            #1;
        end
        `CHK("idle", 1'b0, busy_out)
    endtask
    task automatic end_of_test;
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #(2000 * 100);
        err_total++;
        end_of_test;
    end
    initial begin
        {instr_valid_in, mode_alt_in, int_sys_en_in, format_sw_in, slow_in} = '0;
        {tape_trap_en_in, instr_trap_en_in, mt_finish_in, mt_word_in} = '0;
        {instr_in, word2_in, acc_in, mt_check_in, data_field_in} = '0;
        check_val_in = 12'hfff;
        rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1;
        `CHK("save", VEC_PRI_SAVE, int_save_out)
        `CHK("jump", VEC_PRI_JUMP, int_jump_out)
        op(OP_ACC_TO_EXT, 12'h210, '0);
        op(OP_EXT_TO_ACC, '0, '0);
        `CHK("readback", 12'h210, acc_out)
        op(OP_LOAD_SETUP, 12'h160, '0);
        op(12'h1c0, '0, 12'h0f5);
        `CHK("ext addr", {3'h1, 12'h160}, mem_addr_out)
        `CHK("block", 11'h0f5, tape_cmd_out.block)
        `CHK("stall", 1'b1, stall_out)
        op(OP_SKIP_DONE | 12'h010, '0, '0);
        `CHK("skip busy", 1'b1, skip_out)
        wait_idle;
        `CHK("check", 12'hfff, acc_out)
        op(OP_SKIP_DONE, '0, '0);
        `CHK("skip idle", 1'b1, skip_out)
        @(posedge ref_clk_in);
        slow_in <= 1'b1;
        int_sys_en_in <= 1'b1;
        mode_alt_in <= 1'b1;
        op(OP_LOAD_SETUP, 12'hffe, '0);
        op(OP_ACC_TO_EXT, 12'h253, '0);
        op(12'h1c8, '0, 12'h7ff);
        `CHK("unit", 3'h7, tape_cmd_out.unit)
        wait_idle;
        `CHK("wrap", {3'h1, 12'h002}, mem_addr_out)
        op(OP_MAINT_LOAD, 12'h040, '0);
        `CHK("done skip", 1'b1, skip_out)
        `CHK("int", 1'b1, int_req_out)
        `CHK("alt save", VEC_ALT_SAVE, int_save_out)
        `CHK("alt jump", VEC_ALT_JUMP, int_jump_out)
        op(OP_MAINT_LOAD, 12'h080, '0);
        op(OP_MAINT_LOAD, 12'h040, '0);
        `CHK("cleared", 1'b0, skip_out)
        `CHK("int off", 1'b0, int_req_out)
        @(posedge ref_clk_in);
        data_field_in <= 3'h5;
        check_val_in <= 12'habc;
        op(OP_ACC_TO_EXT, 12'h008, '0);
        op(12'h1c0, '0, 12'h003);
        `CHK("no stall", 1'b0, stall_out)
        `CHK("std addr", {3'h5, 12'h000}, mem_addr_out)
        `CHK("run", 8'h01, unit_run_out)
        wait_idle;
        `CHK("acc kept", 12'hfff, acc_out)
        op(OP_TAPE_ACC, '0, '0);
        `CHK("tape acc", 12'habc, acc_out)
        op(12'h1c8, '0, 12'h003);
        `CHK("run", 8'h02, unit_run_out)
        wait_idle;
        op(OP_ACC_TO_EXT, 12'h00c, '0);
        op(12'h1c0, '0, 12'h003);
        `CHK("hold", 8'h03, unit_run_out)
        wait_idle;
        @(posedge ref_clk_in);
        format_sw_in <= 1'b1;
        op(OP_ACC_TO_EXT, 12'h080, '0);
        `CHK("format", 1'b1, format_en_out)
        @(posedge ref_clk_in);
        format_sw_in <= 1'b0;
        op(OP_ACC_TO_EXT, 12'h080, '0);
        `CHK("no format", 1'b0, format_en_out)
        op(OP_ACC_TO_EXT, 12'h020, '0);
        `CHK("maint", 1'b1, maint_mode_out)
        op(12'h1c0, '0, 12'h003);
        repeat (14) @(posedge ref_clk_in);
        #1;
        `CHK("blocked", 1'b1, busy_out)
        @(posedge ref_clk_in);
        mt_word_in <= 1'b1;
        @(posedge ref_clk_in);
        mt_word_in <= 1'b0;
        mt_check_in <= 12'h123;
        mt_finish_in <= 1'b1;
        @(posedge ref_clk_in);
        mt_finish_in <= 1'b0;
        wait_idle;
        `CHK("mt check", 12'h123, acc_out)
        `CHK("mt addr", {3'h5, 12'h001}, mem_addr_out)
        @(posedge ref_clk_in);
        tape_trap_en_in <= 1'b1;
        instr_trap_en_in <= 1'b1;
        op(12'h1c0, '0, 12'h003);
        `CHK("trap", 1'b1, trap_out)
        `CHK("no start", 1'b0, tape_start_out)
        `CHK("trap loc", VEC_TRAP, trap_addr_out)
        end_of_test;
    end
endmodule
